// [pkg/mie_pkg.sv]
package mie_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_MOT_STAT = 8'h09;
  localparam logic [7:0] ADDR_DATA_STAT = 8'h0a;
  localparam logic [7:0] ADDR_AXIS_INFO = 8'h0b;
  localparam logic [7:0] ADDR_MOT_EN = 8'h16;
  localparam logic [7:0] ADDR_DATA_EN = 8'h17;
  localparam logic [7:0] ADDR_MAP_ONE = 8'h19;
  localparam logic [7:0] ADDR_MAP_DATA = 8'h1a;
  localparam logic [7:0] ADDR_MAP_TWO = 8'h1b;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h20;
  localparam logic [7:0] ADDR_LATCH = 8'h21;
  localparam logic [7:0] ADDR_PERSIST = 8'h27;
  localparam logic [7:0] ADDR_MOT_TH = 8'h28;
  localparam logic [7:0] ADDR_KNOCK_TIM = 8'h2a;
  localparam logic [7:0] ADDR_KNOCK_TH = 8'h2b;
  // ----------------------------------------
  // writable field masks and reset values
  // ----------------------------------------
  localparam logic [7:0] MASK_MOT_EN = 8'h37;
  localparam logic [7:0] MASK_DATA_EN = 8'h01;
  localparam logic [7:0] MASK_MAP = 8'h07;
  localparam logic [7:0] MASK_MAP_DATA = 8'h03;
  localparam logic [7:0] MASK_PIN_CFG = 8'h0f;
  localparam logic [7:0] MASK_LATCH = 8'h0f;
  localparam logic [7:0] MASK_PERSIST = 8'h03;
  localparam logic [7:0] MASK_KNOCK_TIM = 8'hc7;
  localparam logic [7:0] MASK_KNOCK_TH = 8'h1f;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PIN_CFG = 8'h05;
  localparam logic [7:0] RST_MOT_TH = 8'h14;
  localparam logic [7:0] RST_KNOCK_TIM = 8'h04;
  localparam logic [7:0] RST_KNOCK_TH = 8'h0a;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_SLOPE = 2;
  localparam int B_DTAP = 4;
  localparam int B_STAP = 5;
  localparam int B_RESET_INT = 7;
  localparam int B_SHOCK = 7;
  localparam int B_QUIET = 6;
  localparam logic [2:0] LATCHED_CODE = 3'h7;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 500000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_US = TICK_NS / 1000;
  localparam int GAP_NS = 50000;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHOCK0_US = 50000;
  localparam int SHOCK1_US = 75000;
  localparam int QUIET0_US = 30000;
  localparam int QUIET1_US = 20000;
  localparam int AUTOCLR_US = 12500;
  localparam int DTAP_US [8] = '{50000, 100000, 150000, 200000, 250000, 375000, 500000, 700000};
  localparam int TMR_W = 11;
  localparam logic [TMR_W-1:0] SHOCK0_TK = TMR_W'(SHOCK0_US / TICK_US);
  localparam logic [TMR_W-1:0] SHOCK1_TK = TMR_W'(SHOCK1_US / TICK_US);
  localparam logic [TMR_W-1:0] QUIET0_TK = TMR_W'(QUIET0_US / TICK_US);
  localparam logic [TMR_W-1:0] QUIET1_TK = TMR_W'(QUIET1_US / TICK_US);
  localparam logic [4:0] AUTOCLR_TK = 5'(AUTOCLR_US / TICK_US);
  localparam int ACC_W = 12;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic signed [ACC_W-1:0] z;
    logic signed [ACC_W-1:0] y;
    logic signed [ACC_W-1:0] x;
  } mie_acc_s;
  typedef enum logic [5:0] {
    TAP_IDLE = 6'h01,
    TAP_SHOCK = 6'h02,
    TAP_QUIET = 6'h04,
    TAP_WAIT = 6'h08,
    TAP_SHOCK2 = 6'h10,
    TAP_QUIET2 = 6'h20
  } mie_tap_e;
endpackage : mie_pkg

// [rtl/mie_top.sv]
`timescale 1ns/100ps
// Contract
// - level bit: 1 active high, 0 active low
// - driver bit: 1 open-drain, 0 push-pull
// - new-data raised after fresh z sample
// - new-data clears at acquisition start, 50us low
// - new-data never latched
// - new-data enable bit and status bit
// - first new-data after wake-up delayed
// - slope is abs difference of successive samples
// - slope threshold step is four data lsb
// - raise and clear after N consecutive points
// - any enabled axis triggers, all clear
// - slope status, one-hot first axis bits
// - slope sign held until next trigger
// - tap event: slope over tap threshold
// - single/double tap enables and status bits
// - shock window ignores, quiet window cancels
// - single tap after shock+quiet, clears 12.5ms
// - double tap within window, clears 12.5ms
// - shock 50/75ms, quiet 30/20ms select
// - double-tap window table 50 to 700ms
// - pin is OR of mapped enabled interrupts
// - disabling clears its status bits
// - status sets only on new sample
// - latched mode cleared by reset bit
module mie_top
  import mie_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int SETTLE_SAMPLES = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // acceleration data path
  input wire logic sampleValid,
  input wire mie_acc_s sample,
  input wire logic acqStart,
  input wire logic wakeUp,
  // interrupt pins
  output logic irqPinOneOut,
  output logic irqPinOneOe,
  output logic irqPinTwoOut,
  output logic irqPinTwoOe
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [ACC_W:0] absDiff(input logic [ACC_W:0] d);
    return d[ACC_W] ? {1'b0, ACC_W'(~d[ACC_W-1:0]) + ACC_W'(1)} : d;
  endfunction : absDiff
  function automatic logic [1:0] pinDrive(input logic act, input logic lvl, input logic od);
    return od ? {lvl, act} : {act ? lvl : ~lvl, 1'b1};
  endfunction : pinDrive
  function automatic logic [TMR_W-1:0] dtapTicks(input logic [2:0] c);
    return TMR_W'(DTAP_US[c] / TICK_US);
  endfunction : dtapTicks

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] motEn_q, dataEn_q, mapOne_q, mapTwo_q, mapData_q, pinCfg_q;
  logic [7:0] latch_q, persist_q, motTh_q, knockTim_q, knockTh_q;
  wire logic wrMotEn = regWrEn && regAddr == ADDR_MOT_EN;
  wire logic wrDataEn = regWrEn && regAddr == ADDR_DATA_EN;
  wire logic wrLatch = regWrEn && regAddr == ADDR_LATCH;
  wire logic latched = latch_q[2:0] == LATCHED_CODE;
  wire logic latchClr = wrLatch && regWrData[B_RESET_INT] && latched;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      motEn_q <= RST_ZERO;
      dataEn_q <= RST_ZERO;
      mapOne_q <= RST_ZERO;
      mapTwo_q <= RST_ZERO;
      mapData_q <= RST_ZERO;
      pinCfg_q <= RST_PIN_CFG;
      latch_q <= RST_ZERO;
      persist_q <= RST_ZERO;
      motTh_q <= RST_MOT_TH;
      knockTim_q <= RST_KNOCK_TIM;
      knockTh_q <= RST_KNOCK_TH;
    end else if (regWrEn) begin
      if (wrMotEn) motEn_q <= regWrData & MASK_MOT_EN;
      if (wrDataEn) dataEn_q <= regWrData & MASK_DATA_EN;
      if (regAddr == ADDR_MAP_ONE) mapOne_q <= regWrData & MASK_MAP;
      if (regAddr == ADDR_MAP_TWO) mapTwo_q <= regWrData & MASK_MAP;
      if (regAddr == ADDR_MAP_DATA) mapData_q <= regWrData & MASK_MAP_DATA;
      if (regAddr == ADDR_PIN_CFG) pinCfg_q <= regWrData & MASK_PIN_CFG;
      if (wrLatch) latch_q <= regWrData & MASK_LATCH;
      if (regAddr == ADDR_PERSIST) persist_q <= regWrData & MASK_PERSIST;
      if (regAddr == ADDR_MOT_TH) motTh_q <= regWrData;
      if (regAddr == ADDR_KNOCK_TIM) knockTim_q <= regWrData & MASK_KNOCK_TIM;
      if (regAddr == ADDR_KNOCK_TH) knockTh_q <= regWrData & MASK_KNOCK_TH;
    end
  end

  // ----------------------------------------
  // per-axis slope
  // ----------------------------------------
  mie_acc_s prev_q;
  logic havePrev_q;
  logic [2:0] slopeHit, tapHit, slopeNeg;
  wire logic [ACC_W:0] slopeLim = (ACC_W+1)'({motTh_q, 2'b00});
  wire logic [ACC_W:0] tapLim = (ACC_W+1)'({knockTh_q[4:0], 6'h00});
  for (genvar i = 0; i < 3; i++) begin : g_axis
    wire logic [ACC_W-1:0] cur = sample[i*ACC_W +: ACC_W];
    wire logic [ACC_W-1:0] prv = prev_q[i*ACC_W +: ACC_W];
    wire logic [ACC_W:0] diff = {cur[ACC_W-1], cur} - {prv[ACC_W-1], prv};
    wire logic [ACC_W:0] mag = absDiff(diff);
    assign slopeNeg[i] = diff[ACC_W];
    assign slopeHit[i] = motEn_q[i] && mag > slopeLim;
    assign tapHit[i] = mag > tapLim;
  end
  wire logic step = sampleValid && havePrev_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_q <= '0;
      havePrev_q <= 1'b0;
    end else if (sampleValid) begin
      prev_q <= sample;
      havePrev_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // slope engine
  // ----------------------------------------
  logic [2:0] overCnt_q, underCnt_q, slopeFirst_q;
  logic slopeSt_q, slopeSign_q;
  wire logic slopeOn = |motEn_q[2:0];
  wire logic anyOver = |slopeHit;
  wire logic [2:0] nReq = {1'b0, persist_q[1:0]} + 3'h1;
  wire logic [2:0] overNext = anyOver ? (overCnt_q >= nReq ? nReq : overCnt_q + 3'h1) : 3'h0;
  wire logic [2:0] underNext = anyOver ? 3'h0 : (underCnt_q >= nReq ? nReq : underCnt_q + 3'h1);
  wire logic slopeRaise = step && !slopeSt_q && overNext == nReq;
  wire logic slopeFall = step && !latched && underNext == nReq;
  wire logic [2:0] firstAxis = slopeHit[0] ? 3'h1 : (slopeHit[1] ? 3'h2 : 3'h4);
  wire logic firstNeg = slopeHit[0] ? slopeNeg[0] : (slopeHit[1] ? slopeNeg[1] : slopeNeg[2]);
  wire logic slopeSt_d = !slopeOn ? 1'b0 : (slopeRaise ? 1'b1 :
                         ((latchClr || slopeFall) ? 1'b0 : slopeSt_q));
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overCnt_q <= 3'h0;
      underCnt_q <= 3'h0;
      slopeSt_q <= 1'b0;
      slopeFirst_q <= 3'h0;
      slopeSign_q <= 1'b0;
    end else begin
      if (step) overCnt_q <= overNext;
      if (step) underCnt_q <= underNext;
      slopeSt_q <= slopeSt_d;
      if (slopeRaise && slopeOn) begin
        slopeFirst_q <= firstAxis;
        slopeSign_q <= firstNeg;
      end else if (!slopeSt_d) slopeFirst_q <= 3'h0;
    end
  end

  // ----------------------------------------
  // new-data engine
  // ----------------------------------------
  logic dataSt_q;
  logic [11:0] gapCnt_q;
  logic [3:0] settle_q;
  wire logic gapOk = gapCnt_q == 12'(GAP_CYC);
  wire logic dataSet = dataEn_q[0] && sampleValid && settle_q == 4'h0 && gapOk;
  wire logic dataSt_d = !dataEn_q[0] ? 1'b0 : (dataSet ? 1'b1 :
                        (acqStart ? 1'b0 : dataSt_q));
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dataSt_q <= 1'b0;
      gapCnt_q <= 12'(GAP_CYC);
      settle_q <= 4'h0;
    end else begin
      dataSt_q <= dataSt_d;
      gapCnt_q <= dataSt_q ? 12'h000 : (gapOk ? gapCnt_q : gapCnt_q + 12'h001);
      if (wakeUp) settle_q <= 4'(SETTLE_SAMPLES);
      else if (sampleValid && settle_q != 4'h0) settle_q <= settle_q - 4'h1;
    end
  end

  // ----------------------------------------
  // tick and tap engine
  // ----------------------------------------
  logic [15:0] tickCnt_q;
  logic [TMR_W-1:0] tapTmr_q;
  logic [4:0] sHold_q, dHold_q;
  logic sTapSt_q, dTapSt_q, candSign_q, tapSign_q;
  logic [2:0] candAxis_q, tapFirst_q;
  mie_tap_e tapState_q, tapState_d;
  wire logic tick = tickCnt_q == 16'(TICK_CYCLES - 1);
  wire logic sEn = motEn_q[B_STAP];
  wire logic dEn = motEn_q[B_DTAP];
  wire logic tapEvent = step && |tapHit;
  wire logic tmrDone = tapTmr_q == '0;
  wire logic [TMR_W-1:0] shockTk = knockTim_q[B_SHOCK] ? SHOCK1_TK : SHOCK0_TK;
  wire logic [TMR_W-1:0] quietTk = knockTim_q[B_QUIET] ? QUIET1_TK : QUIET0_TK;
  wire logic [TMR_W-1:0] durTk = dtapTicks(knockTim_q[2:0]);
  wire logic inQuiet = tapState_q == TAP_QUIET || tapState_q == TAP_QUIET2;
  wire logic quietEnd = step && inQuiet && tmrDone && !tapEvent;
  wire logic sRaise = quietEnd && tapState_q == TAP_QUIET && sEn;
  wire logic dRaise = quietEnd && tapState_q == TAP_QUIET2 && dEn;
  wire logic sAuto = sampleValid && sHold_q == 5'h00 && !latched;
  wire logic dAuto = sampleValid && dHold_q == 5'h00 && !latched;
  wire logic sTapSt_d = !sEn ? 1'b0 : (sRaise ? 1'b1 :
                        ((latchClr || sAuto) ? 1'b0 : sTapSt_q));
  wire logic dTapSt_d = !dEn ? 1'b0 : (dRaise ? 1'b1 :
                        ((latchClr || dAuto) ? 1'b0 : dTapSt_q));
  wire logic tmrLoad = tapState_d != tapState_q;
  wire logic [TMR_W-1:0] tmrLoadVal = (tapState_d == TAP_QUIET || tapState_d == TAP_QUIET2) ?
                                      quietTk : (tapState_d == TAP_WAIT ? durTk : shockTk);
  always_comb begin
    tapState_d = tapState_q;
    if (!(sEn || dEn)) tapState_d = TAP_IDLE;
    else if (step) begin
      case (tapState_q)
        TAP_IDLE: if (tapEvent) tapState_d = TAP_SHOCK;
        TAP_SHOCK: if (tmrDone) tapState_d = TAP_QUIET;
        TAP_QUIET: begin
          if (tapEvent) tapState_d = TAP_IDLE;
          else if (tmrDone) tapState_d = dEn ? TAP_WAIT : TAP_IDLE;
        end
        TAP_WAIT: begin
          if (tapEvent) tapState_d = TAP_SHOCK2;
          else if (tmrDone) tapState_d = TAP_IDLE;
        end
        TAP_SHOCK2: if (tmrDone) tapState_d = TAP_QUIET2;
        TAP_QUIET2: if (tapEvent || tmrDone) tapState_d = TAP_IDLE;
        default: tapState_d = TAP_IDLE;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tickCnt_q <= 16'h0000;
      tapState_q <= TAP_IDLE;
      tapTmr_q <= '0;
    end else begin
      tickCnt_q <= tick ? 16'h0000 : tickCnt_q + 16'h0001;
      tapState_q <= tapState_d;
      if (tmrLoad) tapTmr_q <= tmrLoadVal;
      else if (tick && !tmrDone) tapTmr_q <= tapTmr_q - TMR_W'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sTapSt_q <= 1'b0;
      dTapSt_q <= 1'b0;
      sHold_q <= 5'h00;
      dHold_q <= 5'h00;
      candAxis_q <= 3'h0;
      candSign_q <= 1'b0;
      tapFirst_q <= 3'h0;
      tapSign_q <= 1'b0;
    end else begin
      sTapSt_q <= sTapSt_d;
      dTapSt_q <= dTapSt_d;
      if (sRaise) sHold_q <= AUTOCLR_TK;
      else if (tick && sHold_q != 5'h00) sHold_q <= sHold_q - 5'h01;
      if (dRaise) dHold_q <= AUTOCLR_TK;
      else if (tick && dHold_q != 5'h00) dHold_q <= dHold_q - 5'h01;
      if (tapState_q == TAP_IDLE && tapEvent) begin
        candAxis_q <= tapHit[0] ? 3'h1 : (tapHit[1] ? 3'h2 : 3'h4);
        candSign_q <= tapHit[0] ? slopeNeg[0] : (tapHit[1] ? slopeNeg[1] : slopeNeg[2]);
      end
      if (sRaise || dRaise) begin
        tapFirst_q <= candAxis_q;
        tapSign_q <= candSign_q;
      end else if (!sTapSt_d && !dTapSt_d) tapFirst_q <= 3'h0;
    end
  end

  // ----------------------------------------
  // pins and readback
  // ----------------------------------------
  wire logic actOne = (slopeSt_q & mapOne_q[0]) | (dTapSt_q & mapOne_q[1]) |
                      (sTapSt_q & mapOne_q[2]) | (dataSt_q & mapData_q[0]);
  wire logic actTwo = (slopeSt_q & mapTwo_q[0]) | (dTapSt_q & mapTwo_q[1]) |
                      (sTapSt_q & mapTwo_q[2]) | (dataSt_q & mapData_q[1]);
  wire logic [1:0] driveOne = pinDrive(actOne, pinCfg_q[0], pinCfg_q[1]);
  wire logic [1:0] driveTwo = pinDrive(actTwo, pinCfg_q[2], pinCfg_q[3]);
  wire logic [7:0] motStat = 8'(({2'b00, sTapSt_q, dTapSt_q, 1'b0, slopeSt_q, 2'b00}));
  wire logic [7:0] axisInfo = {tapSign_q, tapFirst_q, slopeSign_q, slopeFirst_q};
  wire logic [7:0] rdMux =
    regAddr == ADDR_MOT_STAT ? motStat :
    regAddr == ADDR_DATA_STAT ? {7'h00, dataSt_q} :
    regAddr == ADDR_AXIS_INFO ? axisInfo :
    regAddr == ADDR_MOT_EN ? motEn_q :
    regAddr == ADDR_DATA_EN ? dataEn_q :
    regAddr == ADDR_MAP_ONE ? mapOne_q :
    regAddr == ADDR_MAP_DATA ? mapData_q :
    regAddr == ADDR_MAP_TWO ? mapTwo_q :
    regAddr == ADDR_PIN_CFG ? pinCfg_q :
    regAddr == ADDR_LATCH ? latch_q :
    regAddr == ADDR_PERSIST ? persist_q :
    regAddr == ADDR_MOT_TH ? motTh_q :
    regAddr == ADDR_KNOCK_TIM ? knockTim_q :
    regAddr == ADDR_KNOCK_TH ? knockTh_q : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdData <= 8'h00;
      irqPinOneOut <= 1'b0;
      irqPinOneOe <= 1'b0;
      irqPinTwoOut <= 1'b0;
      irqPinTwoOe <= 1'b0;
    end else begin
      if (regRdEn) regRdData <= rdMux;
      {irqPinOneOut, irqPinOneOe} <= driveOne;
      {irqPinTwoOut, irqPinTwoOe} <= driveTwo;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [11:0] lowRun_q;
  always_ff @(posedge ref_clk) begin
    if (rst) lowRun_q <= 12'(GAP_CYC);
    else if (dataSt_q) lowRun_q <= 12'h000;
    else if (lowRun_q != 12'hfff) lowRun_q <= lowRun_q + 12'h001;
  end
  sequence s_quietDone;
    tapState_q == TAP_QUIET && step && tmrDone && !tapEvent && sEn;
  endsequence
  property p_pinLevel;
    !$past(pinCfg_q[1]) && !$past(rst) |->
      irqPinOneOe && irqPinOneOut == ($past(actOne) ~^ $past(pinCfg_q[0]));
  endproperty
  a_pinLevel: assert property (p_pinLevel) else $error("pin one level wrong");
  property p_openDrain;
    $past(pinCfg_q[3]) && !$past(rst) |->
      irqPinTwoOe == $past(actTwo) && irqPinTwoOut == $past(pinCfg_q[2]);
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("pin two open-drain wrong");
  property p_dataGap;
    $rose(dataSt_q) |-> $past(lowRun_q) >= 12'(GAP_CYC);
  endproperty
  a_dataGap: assert property (p_dataGap) else $error("new-data low time too short");
  property p_dataClr;
    dataSt_q && acqStart |=> !dataSt_q;
  endproperty
  a_dataClr: assert property (p_dataClr) else $error("new-data not cleared");
  property p_dataOff;
    !dataEn_q[0] |=> !dataSt_q;
  endproperty
  a_dataOff: assert property (p_dataOff) else $error("new-data set while disabled");
  property p_slopeOff;
    motEn_q[2:0] == 3'h0 |=> !slopeSt_q ##1 !slopeSt_q;
  endproperty
  a_slopeOff: assert property (p_slopeOff) else $error("slope set while off");
  property p_firstHot;
    slopeSt_q |-> $onehot(slopeFirst_q);
  endproperty
  a_firstHot: assert property (p_firstHot) else $error("first-axis bits not one-hot");
  property p_slopeRise;
    $rose(slopeSt_q) |-> $past(step) && $past(overNext) == $past(nReq);
  endproperty
  a_slopeRise: assert property (p_slopeRise) else $error("slope raised early");
  property p_signHeld;
    $changed(slopeSign_q) |-> $rose(slopeSt_q);
  endproperty
  a_signHeld: assert property (p_signHeld) else $error("slope sign changed");
  property p_singleTap;
    s_quietDone |=> sTapSt_q && tapFirst_q != 3'h0;
  endproperty
  a_singleTap: assert property (p_singleTap) else $error("single tap not raised");
endmodule : mie_top

// [tb/mie_bench.sv]
`timescale 1ns/100ps
module mie_bench
  import mie_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic regWrEn = 1'b0, regRdEn = 1'b0, sampleValid = 1'b0, acqStart = 1'b0, wakeUp = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, cfgPins = 8'h05;
  mie_acc_s sample = '0;
  logic pinOneOut, pinOneOe, pinTwoOut, pinTwoOe, oneSeen, twoSeen;
  int err_count = 0, checked = 0;
  logic [7:0] rAddr [6] = '{ADDR_PIN_CFG, ADDR_MOT_TH, ADDR_KNOCK_TIM, ADDR_KNOCK_TH,
    ADDR_MOT_EN, 8'h30};
  logic [7:0] rRst [6] = '{RST_PIN_CFG, RST_MOT_TH, RST_KNOCK_TIM, RST_KNOCK_TH,
    RST_ZERO, RST_ZERO};
  mie_top #(.TICK_CYCLES(20), .SETTLE_SAMPLES(2)) mie_top_i (.ref_clk(ref_clk), .rst(rst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .sampleValid(sampleValid), .sample(sample), .acqStart(acqStart),
    .wakeUp(wakeUp), .irqPinOneOut(pinOneOut), .irqPinOneOe(pinOneOe),
    .irqPinTwoOut(pinTwoOut), .irqPinTwoOe(pinTwoOe));
  mie_host_pin mie_host_pin_i (.pinOneOut(pinOneOut), .pinOneOe(pinOneOe),
    .pinTwoOut(pinTwoOut), .pinTwoOe(pinTwoOe), .oneActiveHigh(cfgPins[0]),
    .twoActiveHigh(cfgPins[2]), .oneSeen(oneSeen), .twoSeen(twoSeen));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge ref_clk) #1;
    regWrEn = 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk) #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge ref_clk) #1;
    regRdEn = 1'b0;
    chk8(regRdData & m, e);
  endtask : rdc
  task automatic smp(input int x, input int gap);
    @(posedge ref_clk) #1;
    sampleValid = 1'b1;
    sample.x = 12'(x);
    @(posedge ref_clk) #1;
    sampleValid = 1'b0;
    repeat (gap) @(posedge ref_clk);
  endtask : smp
  task automatic smpn(input int x, input int n);
    for (int i = 0; i < n; i++) smp(x, 100);
  endtask : smpn
  task automatic pulse(input bit wake);
    @(posedge ref_clk) #1;
    if (wake) wakeUp = 1'b1;
    else acqStart = 1'b1;
    @(posedge ref_clk) #1;
    wakeUp = 1'b0;
    acqStart = 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : pulse
  task automatic late(input logic [7:0] e);
    repeat (2100) @(posedge ref_clk);
    smp(0, 3);
    rdc(ADDR_DATA_STAT, 8'h01, e);
  endtask : late
  task automatic dtap(input logic [7:0] e);
    smp(600, 100);
    smpn(600, 52);
    smp(-600, 100);
    smpn(-600, 32);
    rdc(ADDR_MOT_STAT, 8'h10, e);
  endtask : dtap
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------
  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 6; i++) rdc(rAddr[i], 8'hff, rRst[i]);
    wr(8'h30, 8'hff);
    rdc(8'h30, 8'hff, 8'h00);
    wr(ADDR_PERSIST, 8'hff);
    rdc(ADDR_PERSIST, 8'hff, MASK_PERSIST);
    $display("test registers done");
    wr(ADDR_PERSIST, 8'h01);
    wr(ADDR_MOT_TH, 8'h01);
    wr(ADDR_MOT_EN, 8'h01);
    wr(ADDR_MAP_ONE, 8'h01);
    smp(0, 3);
    smp(100, 3);
    rdc(ADDR_MOT_STAT, 8'h04, 8'h00);
    smp(200, 3);
    rdc(ADDR_MOT_STAT, 8'h04, 8'h04);
    rdc(ADDR_AXIS_INFO, 8'h0f, 8'h01);
    chk1(oneSeen, 1'b1);
    smp(200, 3);
    rdc(ADDR_MOT_STAT, 8'h04, 8'h04);
    smp(200, 3);
    rdc(ADDR_MOT_STAT, 8'h04, 8'h00);
    rdc(ADDR_AXIS_INFO, 8'h0f, 8'h00);
    smp(100, 3);
    smp(0, 3);
    rdc(ADDR_AXIS_INFO, 8'h0f, 8'h09);
    wr(ADDR_MOT_EN, 8'h00);
    rdc(ADDR_MOT_STAT, 8'h04, 8'h00);
    wr(ADDR_MOT_EN, 8'h02);
    smp(300, 3);
    smp(400, 3);
    rdc(ADDR_MOT_STAT, 8'h04, 8'h00);
    wr(ADDR_LATCH, 8'h07);
    wr(ADDR_MOT_EN, 8'h01);
    smp(500, 3);
    smp(600, 3);
    smp(600, 3);
    smp(600, 3);
    smp(600, 3);
    rdc(ADDR_MOT_STAT, 8'h04, 8'h04);
    wr(ADDR_LATCH, 8'h87);
    rdc(ADDR_MOT_STAT, 8'h04, 8'h00);
    wr(ADDR_LATCH, 8'h00);
    $display("test slope done");
    wr(ADDR_MOT_EN, 8'h20);
    wr(ADDR_MAP_ONE, 8'h04);
    smp(-600, 100);
    smpn(-600, 4);
    smpn(600, 30);
    rdc(ADDR_MOT_STAT, 8'h20, 8'h20);
    chk1(oneSeen, 1'b1);
    smpn(600, 10);
    rdc(ADDR_MOT_STAT, 8'h20, 8'h00);
    smp(-600, 100);
    smpn(-600, 25);
    smpn(600, 10);
    rdc(ADDR_MOT_STAT, 8'h20, 8'h00);
    smpn(600, 40);
    wr(ADDR_KNOCK_TIM, 8'hc4);
    smp(-600, 100);
    smpn(-600, 34);
    rdc(ADDR_MOT_STAT, 8'h20, 8'h00);
    smpn(-600, 5);
    rdc(ADDR_MOT_STAT, 8'h20, 8'h20);
    wr(ADDR_MOT_EN, 8'h10);
    wr(ADDR_MAP_ONE, 8'h02);
    wr(ADDR_KNOCK_TIM, 8'h01);
    dtap(8'h10);
    rdc(ADDR_AXIS_INFO, 8'hf0, 8'h10);
    chk1(oneSeen, 1'b1);
    wr(ADDR_KNOCK_TIM, 8'h00);
    dtap(8'h00);
    $display("test tap done");
    wr(ADDR_MOT_EN, 8'h00);
    wr(ADDR_MAP_ONE, 8'h00);
    wr(ADDR_LATCH, 8'h07);
    cfgPins = 8'h0e;
    wr(ADDR_PIN_CFG, cfgPins);
    wr(ADDR_DATA_EN, 8'h01);
    wr(ADDR_MAP_DATA, 8'h03);
    late(8'h01);
    chk1(oneSeen, 1'b1);
    chk1(pinOneOe, 1'b1);
    chk1(pinOneOut, 1'b0);
    chk1(twoSeen, 1'b1);
    chk1(pinTwoOut, 1'b1);
    pulse(1'b0);
    rdc(ADDR_DATA_STAT, 8'h01, 8'h00);
    chk1(pinOneOe, 1'b0);
    chk1(pinTwoOe, 1'b0);
    smp(0, 3);
    rdc(ADDR_DATA_STAT, 8'h01, 8'h00);
    pulse(1'b1);
    late(8'h00);
    late(8'h00);
    late(8'h01);
    wr(ADDR_DATA_EN, 8'h00);
    rdc(ADDR_DATA_STAT, 8'h01, 8'h00);
    $display("test new data done");
    summarize();
  end
endmodule : mie_bench

// [tb/mie_host_pin.sv]
`timescale 1ns/100ps
// ----------------------------------------
// host view of both interrupt pins
// ----------------------------------------
module mie_host_pin (
  // pin one driver
  input wire logic pinOneOut,
  input wire logic pinOneOe,
  // pin two driver
  input wire logic pinTwoOut,
  input wire logic pinTwoOe,
  // configured active levels
  input wire logic oneActiveHigh,
  input wire logic twoActiveHigh,
  // host decision
  output logic oneSeen,
  output logic twoSeen
);
  logic oneLvl, twoLvl;
  // released pin sits at the resistor level, the inactive one
  assign oneLvl = pinOneOe ? pinOneOut : ~oneActiveHigh;
  assign twoLvl = pinTwoOe ? pinTwoOut : ~twoActiveHigh;
  assign oneSeen = (oneLvl == oneActiveHigh);
  assign twoSeen = (twoLvl == twoActiveHigh);
endmodule : mie_host_pin
